// file: design/hsi_status_irq.v
// Headset status, reset flag, and interrupt enable registers
`timescale 1ns/1ps
`default_nettype none
`include "hsi_regs.vh"

// How it works
// - Bits 7 and 6 of register 0x01 show line loads on tip and ring1.
// - Bits 5 and 4 of register 0x01 show headphone loads on tip and ring1.
// - Bit 2 sets on a debounced button press or release event.
// - Reading register 0x01 clears the button flag; code shows separately.
// - Bit 1 shows whether the latest button/hook event was press or release.
// - After a release event the press bit clears about 0.5 ms later.
// - The press bit is never set while the device sleeps.
// - Register 0x02 bit 3 sets after device reset, clears when read.
// - The reset flag raises the interrupt until the host reads it.
// - Bits 1-0 of register 0x02 encode the jack common contact location.
// - An enabled status source pulls the active-low interrupt line low.
// - Enable bits 7,6,5,3,2,1 of register 0x04, all reset to zero.
// - Hook switch flag sets after debounced mic bias pull-down, clears on read.
// - Insertion status change raises an interrupt when its enable is set.
module hsi_status_irq #(
    parameter RELEASE_CYCLES = `HSI_RELEASE_CYC,
    parameter BTN_W = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Register port, from the serial control logic
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Detection inputs, asynchronous to clk
    input wire line_tip_det,
    input wire line_ring1_det,
    input wire hp_tip_det,
    input wire hp_ring1_det,
    input wire [1:0] common_loc,
    input wire accessory_present,
    input wire mic_present,
    input wire jack_switch_closed,
    input wire sleep_mode,
    // Event pulses from detection logic on clk
    input wire button_event,
    input wire button_pressed,
    input wire [BTN_W-1:0] button_code,
    input wire hook_event,
    input wire hook_pressed,
    input wire detect_done_event,
    input wire slew_done_event,
    // Outputs
    output reg [BTN_W-1:0] button_code_field,
    output reg irq_b
);

    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    localparam SW = 10;
    wire [SW-1:0] async_in;
    reg [SW-1:0] sync_a;
    reg [SW-1:0] sync_b;
    assign async_in = {sleep_mode, jack_switch_closed, mic_present,
                       accessory_present, common_loc, hp_ring1_det,
                       hp_tip_det, line_ring1_det, line_tip_det};

    always @(posedge clk) begin
        if (!rst_b) begin
            sync_a <= {SW{1'b0}};
            sync_b <= {SW{1'b0}};
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
        end
    end

    wire s_line_tip = sync_b[0];
    wire s_line_ring1 = sync_b[1];
    wire s_hp_tip = sync_b[2];
    wire s_hp_ring1 = sync_b[3];
    wire [1:0] s_common = sync_b[5:4];
    wire s_insert = sync_b[6];
    wire s_mic = sync_b[7];
    wire s_jack = sync_b[8];
    wire s_sleep = sync_b[9];

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg button_flag;
    reg press_flag;
    reg dev_reset_flag;
    reg mic_switch_flag;
    reg detect_done_flag;
    reg slew_done_flag;
    reg insert_chg;
    reg mic_chg;
    reg jack_chg;
    reg last_insert;
    reg last_mic;
    reg last_jack;
    reg [7:0] scratch;
    reg [7:0] irq_en1;
    wire release_done;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Strobe qualified by one register offset
    function reg_hit;
        input strobe;
        input [7:0] addr;
        input [7:0] offset;
        begin
            reg_hit = strobe && (addr == offset);
        end
    endfunction

    // Read and write strobes per register
    wire rd_load = reg_hit(reg_rd, reg_addr, `HSI_OFS_LOAD_BTN);
    wire rd_rstc = reg_hit(reg_rd, reg_addr, `HSI_OFS_RST_COM);
    // First status register lives elsewhere; its read still clears
    wire rd_stat1 = reg_hit(reg_rd, reg_addr, `HSI_OFS_STATUS1);
    wire wr_scratch = reg_hit(reg_wr, reg_addr, `HSI_OFS_SCRATCH);
    wire wr_en1 = reg_hit(reg_wr, reg_addr, `HSI_OFS_IRQ_EN1);
    wire any_evt = button_event || hook_event;
    wire rel_start = any_evt && !(button_event ? button_pressed
                                               : hook_pressed);
    // A press cancels any pending release clear
    wire press_evt = any_evt && !rel_start;

    // Sixteen bits hold the 0.5 ms count at 50 MHz
    hsi_release_timer #(
        .CYCLES(RELEASE_CYCLES),
        .CW(16)
    ) u_release (
        .clk(clk),
        .rst_b(rst_b),
        .start(rel_start),
        .cancel(press_evt),
        .done(release_done)
    );

    // ----------------------------------------
    // Button and hook flags
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            button_flag <= 1'b0;
            mic_switch_flag <= 1'b0;
            button_code_field <= {BTN_W{1'b0}};
        end else begin
            // Set wins over clear-on-read
            if (button_event)
                button_flag <= 1'b1;
            else if (rd_load)
                button_flag <= 1'b0;
            if (button_event)
                button_code_field <= button_code;
            if (hook_event)
                mic_switch_flag <= 1'b1;
            else if (rd_load)
                mic_switch_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Press direction and reset flag
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            press_flag <= 1'b0;
            dev_reset_flag <= 1'b1; // Sets on every reset
        end else begin
            // Press asserts at once; release clears after delay
            if (press_evt && !s_sleep)
                press_flag <= 1'b1;
            else if (release_done)
                press_flag <= 1'b0;
            if (rd_rstc)
                dev_reset_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Event and level change latches
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            detect_done_flag <= 1'b0;
            slew_done_flag <= 1'b0;
            insert_chg <= 1'b0;
            mic_chg <= 1'b0;
            jack_chg <= 1'b0;
            last_insert <= 1'b0;
            last_mic <= 1'b0;
            last_jack <= 1'b0;
        end else begin
            last_insert <= s_insert;
            last_mic <= s_mic;
            last_jack <= s_jack;
            // Detect and slew flags clear on a first status read
            if (detect_done_event)
                detect_done_flag <= 1'b1;
            else if (rd_stat1)
                detect_done_flag <= 1'b0;
            if (slew_done_event)
                slew_done_flag <= 1'b1;
            else if (rd_stat1)
                slew_done_flag <= 1'b0;
            // Changes of level sources latch until a status read
            if (s_insert != last_insert)
                insert_chg <= 1'b1;
            else if (rd_stat1)
                insert_chg <= 1'b0;
            if (s_mic != last_mic)
                mic_chg <= 1'b1;
            else if (rd_stat1)
                mic_chg <= 1'b0;
            if (s_jack != last_jack)
                jack_chg <= 1'b1;
            else if (rd_stat1)
                jack_chg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            scratch <= `HSI_RST_SCRATCH;
            irq_en1 <= `HSI_RST_IRQ_EN1;
        end else begin
            if (wr_scratch)
                scratch <= reg_wdata;
            // Bits 4 and 0 kept at zero whatever the host writes
            if (wr_en1)
                irq_en1 <= reg_wdata & `HSI_EN1_WMASK;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `HSI_OFS_LOAD_BTN: begin
                next_rdata[`HSI_BIT_LINE_TIP] = s_line_tip;
                next_rdata[`HSI_BIT_LINE_RING1] = s_line_ring1;
                next_rdata[`HSI_BIT_HP_TIP] = s_hp_tip;
                next_rdata[`HSI_BIT_HP_RING1] = s_hp_ring1;
                next_rdata[`HSI_BIT_BUTTON] = button_flag;
                next_rdata[`HSI_BIT_PRESS] = press_flag;
            end
            `HSI_OFS_RST_COM: begin
                next_rdata[`HSI_BIT_DEV_RESET] = dev_reset_flag;
                next_rdata[1:0] = s_common;
            end
            `HSI_OFS_SCRATCH: next_rdata = scratch;
            `HSI_OFS_IRQ_EN1: next_rdata = irq_en1;
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    // ----------------------------------------
    // Interrupt line
    // ----------------------------------------
    // Reset flag cannot be masked so a reset is never missed
    wire next_irq =
        dev_reset_flag ||
        (irq_en1[`HSI_BIT_EN_INSERT] && insert_chg) ||
        (irq_en1[`HSI_BIT_EN_DETECT] && detect_done_flag) ||
        (irq_en1[`HSI_BIT_EN_SLEW] && slew_done_flag) ||
        (irq_en1[`HSI_BIT_EN_MIC] && mic_chg) ||
        (irq_en1[`HSI_BIT_EN_JACK] && jack_chg) ||
        (irq_en1[`HSI_BIT_EN_HOOK] && mic_switch_flag) ||
        button_flag;

    always @(posedge clk) begin
        if (!rst_b)
            irq_b <= 1'b1;
        else
            irq_b <= !next_irq;
    end

endmodule // hsi_status_irq

`default_nettype wire

// file: design/hsi_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef HSI_REGS_VH
`define HSI_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HSI_ADDR_W 8
`define HSI_OFS_STATUS1 8'h00
`define HSI_OFS_LOAD_BTN 8'h01
`define HSI_OFS_RST_COM 8'h02
`define HSI_OFS_SCRATCH 8'h03
`define HSI_OFS_IRQ_EN1 8'h04

// ----------------------------------------
// Field positions
// ----------------------------------------
`define HSI_BIT_LINE_TIP 7
`define HSI_BIT_LINE_RING1 6
`define HSI_BIT_HP_TIP 5
`define HSI_BIT_HP_RING1 4
`define HSI_BIT_BUTTON 2
`define HSI_BIT_PRESS 1
`define HSI_BIT_DEV_RESET 3
`define HSI_BIT_EN_INSERT 7
`define HSI_BIT_EN_DETECT 6
`define HSI_BIT_EN_SLEW 5
`define HSI_BIT_EN_MIC 3
`define HSI_BIT_EN_JACK 2
`define HSI_BIT_EN_HOOK 1

// Writable bits of the first enable register
`define HSI_EN1_WMASK 8'hEE

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HSI_RST_LOAD_BTN 8'h00
`define HSI_RST_RST_COM 8'h00
`define HSI_RST_SCRATCH 8'h00
`define HSI_RST_IRQ_EN1 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define HSI_CLK_HZ 50000000
`define HSI_RELEASE_US 500
`define HSI_RELEASE_CYC ((`HSI_CLK_HZ / 1000000) * `HSI_RELEASE_US)

`endif

// file: design/hsi_release_timer.v
// Delay timer that clears the press bit after a release event
`timescale 1ns/1ps
`default_nettype none
`include "hsi_regs.vh"

module hsi_release_timer #(
    parameter CYCLES = `HSI_RELEASE_CYC,
    parameter CW = 16
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Control
    input wire start,
    input wire cancel,
    output reg done
);

    reg [CW-1:0] count;
    reg running;

    always @(posedge clk) begin
        if (!rst_b) begin
            count <= {CW{1'b0}};
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (cancel) begin
                running <= 1'b0;
            end else if (start) begin
                count <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
                running <= 1'b1;
            end else if (running) begin
                if (count == {CW{1'b0}}) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // hsi_release_timer

`default_nettype wire

// file: verification/hsi_status_irq_sva.sv
// Checker for the status and interrupt register block
`timescale 1ns/1ps
`default_nettype none
module hsi_status_irq_sva #(
    parameter RELEASE_CYCLES = 20,
    parameter BTN_W = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // Button and interrupt
    input wire button_event,
    input wire button_pressed,
    input wire [BTN_W-1:0] button_code,
    input wire [BTN_W-1:0] button_code_field,
    input wire irq_b
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_rst_irq: assert property ($rose(rst_b) |=> !irq_b)
        else $error("interrupt not raised after reset");
    a_btn_irq: assert property (button_event |=> ##1 !irq_b)
        else $error("button event gave no interrupt");
    a_code_take: assert property (button_event |=>
        button_code_field == $past(button_code))
        else $error("button code not captured");
    a_code_hold: assert property (!button_event |=>
        $stable(button_code_field))
        else $error("button code changed without event");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    a_en_rsv: assert property (reg_rd && reg_addr == 8'h04 |=>
        reg_rdata[4] == 1'b0 && reg_rdata[0] == 1'b0)
        else $error("reserved enable bits read nonzero");
    a_com_rsv: assert property (reg_rd && reg_addr == 8'h02 |=>
        reg_rdata[7:4] == 4'h0 && reg_rdata[2] == 1'b0)
        else $error("reserved status bits read nonzero");
    a_rst_vals: assert property ($rose(rst_b) |->
        reg_rdata == 8'h00 && button_code_field == {BTN_W{1'b0}})
        else $error("outputs not at reset values");
    // Write, one idle cycle, then read back the same enable register
    a_en_write: assert property ((reg_wr && reg_addr == 8'h04) ##2
        (reg_rd && reg_addr == 8'h04) |=>
        reg_rdata == ($past(reg_wdata, 3) & 8'hEE))
        else $error("enable register readback wrong");
    c_press: cover property (button_event && button_pressed);
    c_irq: cover property (!irq_b);
    c_en_wr: cover property (reg_wr && reg_addr == 8'h04);
endmodule // hsi_status_irq_sva

bind hsi_status_irq hsi_status_irq_sva #(
    .RELEASE_CYCLES(RELEASE_CYCLES), .BTN_W(BTN_W)) i_sva (
    .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .button_event(button_event), .button_pressed(button_pressed),
    .button_code(button_code), .button_code_field(button_code_field),
    .irq_b(irq_b));
`default_nettype wire

// file: verification/hsi_host.sv
// Host model driving the register port of the status block
`timescale 1ns/1ps
`default_nettype none
`include "hsi_regs.vh"
module hsi_host (
    // Clock
    input wire clk,
    // Register port
    output var logic reg_wr,
    output var logic reg_rd,
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata
);
    logic [7:0] exp_q[$];
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // ----
    // Bus cycles, launched at the falling edge
    // ----
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = (a == 8'h01 || a == 8'h02) ? 8'h00
                  : (a == `HSI_OFS_IRQ_EN1) ? (d & 8'hFE) : d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask
    // Expected value is queued before the strobe is taken
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // hsi_host
`default_nettype wire

// file: verification/hsi_status_irq_test.sv
// Self-checking bench for the status and interrupt register block
`timescale 1ns/1ps
`default_nettype none
`include "hsi_regs.vh"
module hsi_status_irq_test;
    localparam int REL = 20;
    logic clk, rst_b, reg_wr, reg_rd, rd_d, irq_b;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, code, btn_field, e;
    logic [3:0] loads;
    logic [1:0] common_loc;
    logic acc, sleep, b_ev, b_pr, h_ev, h_pr, dd_ev;
    logic mic, jsw, sl_ev;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    integer seed = 32'h5459;

    hsi_host i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    hsi_status_irq #(.RELEASE_CYCLES(REL), .BTN_W(8)) i_hsi_status_irq (
        .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .line_tip_det(loads[3]), .line_ring1_det(loads[2]),
        .hp_tip_det(loads[1]), .hp_ring1_det(loads[0]),
        .common_loc(common_loc), .accessory_present(acc),
        .mic_present(mic), .jack_switch_closed(jsw), .sleep_mode(sleep),
        .button_event(b_ev), .button_pressed(b_pr), .button_code(code),
        .hook_event(h_ev), .hook_pressed(h_pr),
        .detect_done_event(dd_ev), .slew_done_event(sl_ev),
        .button_code_field(btn_field), .irq_b(irq_b));

    // ----
    // Clock, watchdog and read monitor
    // ----
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        rd_d <= reg_rd;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict;
        end
    end
    // Oldest queued expectation meets the registered read data
    always @(negedge clk) if (rd_d) begin
        e = i_host.exp_q.pop_front();
        chk(reg_rdata, e);
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic ci(input logic x);
        chk({7'h00, irq_b}, {7'h00, x});
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic ev(input logic hook, input logic p);
        @(negedge clk);
        code = 8'($random(seed));
        b_pr = p;
        h_pr = p;
        b_ev = !hook;
        h_ev = hook;
        @(negedge clk);
        b_ev = 1'b0;
        h_ev = 1'b0;
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        rst_b = 1'b0;
        {mic, jsw, sl_ev} = 3'h0;
        {loads, common_loc, acc, sleep, b_ev, b_pr, h_ev, h_pr} = 12'h000;
        dd_ev = 1'b0;
        code = 8'h00;
        w(20);
        rst_b = 1'b1;
        w(2);
        ci(1'b0);
        i_host.rd(8'h04, 8'h00);
        i_host.rd(8'h03, 8'h00);
        i_host.rd(8'h02, 8'h08);
        w(3);
        ci(1'b1);
        i_host.rd(8'h02, 8'h00);
        i_host.wr(8'h04, 8'hFF);
        i_host.rd(8'h04, 8'hEE);
        i_host.wr(8'h05, 8'h11);
        i_host.rd(8'h05, 8'h00);
        i_host.wr(8'h04, 8'h00);
        for (int i = 0; i < 4; i++) begin
            loads = 4'($random(seed));
            common_loc = 2'(i);
            w(4);
            i_host.rd(8'h01, {loads, 4'h0});
            i_host.rd(8'h02, {6'h00, common_loc});
        end
        loads = 4'h0;
        ev(1'b0, 1'b1);
        w(1);
        ci(1'b0);
        chk(btn_field, code);
        i_host.rd(8'h01, 8'h06);
        i_host.rd(8'h01, 8'h02);
        w(2);
        ci(1'b1);
        ev(1'b0, 1'b0);
        i_host.rd(8'h01, 8'h06);
        w(REL + 2);
        i_host.rd(8'h01, 8'h00);
        sleep = 1'b1;
        w(4);
        ev(1'b0, 1'b1);
        i_host.rd(8'h01, 8'h04);
        sleep = 1'b0;
        i_host.wr(8'h04, 8'h02);
        ev(1'b1, 1'b1);
        w(1);
        ci(1'b0);
        i_host.rd(8'h01, 8'h02);
        w(2);
        ci(1'b1);
        i_host.wr(8'h04, 8'h00);
        ev(1'b1, 1'b0);
        w(2);
        ci(1'b1);
        i_host.wr(8'h04, 8'h80);
        acc = 1'b1;
        w(5);
        ci(1'b0);
        i_host.wr(8'h04, 8'h00);
        w(2);
        ci(1'b1);
        i_host.wr(8'h04, 8'h40);
        w(1);
        dd_ev = 1'b1;
        w(1);
        dd_ev = 1'b0;
        w(2);
        ci(1'b0);
        i_host.rd(8'h00, 8'h00);
        w(3);
        ci(1'b1);
        // Mic, jack switch and slew sources, each behind its enable
        i_host.wr(8'h04, 8'h2C);
        for (int k = 0; k < 3; k++) begin
            if (k == 0) mic = 1'b1;
            if (k == 1) jsw = 1'b1;
            sl_ev = (k == 2);
            w(1);
            sl_ev = 1'b0;
            w(4);
            ci(1'b0);
            i_host.rd(8'h00, 8'h00);
            w(3);
            ci(1'b1);
        end
        // Reset in mid-run sets the reset flag again
        rst_b = 1'b0;
        w(4);
        rst_b = 1'b1;
        w(2);
        ci(1'b0);
        i_host.rd(8'h04, 8'h00);
        i_host.rd(8'h02, {4'h0, 1'b1, 1'b0, common_loc});
        give_verdict;
    end
endmodule // hsi_status_irq_test
`default_nettype wire
